// File: design/sacfg_pkg.sv
// sacfg_pkg: register map, field positions, reset values of the sensor alarm config block
// assumes an axi4-lite slave with 32-bit data, one register per aligned word
package sacfg_pkg;

  // ****************************************
  // register indices and address width
  // ****************************************
  localparam logic [7:0] SACFG_IDX_VOLT0_LIMITS = 8'h19;
  localparam logic [7:0] SACFG_IDX_VOLT1_LIMITS = 8'h1A;
  localparam logic [7:0] SACFG_IDX_TEMP_LIMITS = 8'h1B;
  localparam logic [7:0] SACFG_IDX_CAM_EN = 8'h1C;
  localparam logic [7:0] SACFG_IDX_MON_EN = 8'h1D;
  localparam logic [7:0] SACFG_IDX_RET_EN = 8'h1E;
  localparam logic [7:0] SACFG_IDX_SPARE = 8'h1F;
  localparam logic [7:0] SACFG_IDX_SENSOR_CTRL = 8'h40;
  localparam logic [7:0] SACFG_IDX_STATUS = 8'h41;
  localparam logic [7:0] SACFG_IDX_VOLT0_PEAK = 8'h42;
  localparam logic [7:0] SACFG_IDX_VOLT0_FLOOR = 8'h43;
  localparam logic [7:0] SACFG_IDX_VOLT1_PEAK = 8'h44;
  localparam logic [7:0] SACFG_IDX_VOLT1_FLOOR = 8'h45;
  localparam logic [7:0] SACFG_IDX_ALARM = 8'h46;
  localparam int SACFG_ADDR_W = 10;

  // ****************************************
  // field positions
  // ****************************************
  localparam int SACFG_UPPER_LSB = 4;
  localparam int SACFG_LOWER_LSB = 0;
  localparam int SACFG_LIMIT_W = 3;
  localparam int SACFG_MON_EN_LSB = 2;
  localparam int SACFG_VSEL_LSB = 0;
  // status bits: 0 volt0 under, 1 volt0 over, 2 volt1 under, 3 volt1 over, 4 temp under, 5 temp over
  localparam int SACFG_ST_VOLT0_UNDER_ALARM_EN = 0;
  localparam int SACFG_ST_VOLT0_OVER_ALARM_EN = 1;
  localparam int SACFG_ST_VOLT1_UNDER_ALARM_EN = 2;
  localparam int SACFG_ST_VOLT1_OVER_ALARM_EN = 3;
  localparam int SACFG_ST_T_UNDER = 4;
  localparam int SACFG_ST_T_OVER = 5;

  // ****************************************
  // reset values, write masks and monitor-on code
  // ****************************************
  localparam logic [7:0] SACFG_RST_LIMITS = 8'h62;
  localparam logic [7:0] SACFG_RST_CAM_EN = 8'h3F;
  localparam logic [7:0] SACFG_RST_MON_EN = 8'h00;
  localparam logic [7:0] SACFG_RST_RET_EN = 8'h00;
  localparam logic [7:0] SACFG_RST_SPARE = 8'h00;
  localparam logic [7:0] SACFG_RST_SENSOR_CTRL = 8'h0C;
  localparam logic [7:0] SACFG_MASK_LIMITS = 8'h77;
  localparam logic [7:0] SACFG_MASK_CAM_EN = 8'h3F;
  localparam logic [7:0] SACFG_MASK_MON_EN = 8'h3F;
  localparam logic [7:0] SACFG_MASK_RET_EN = 8'h03;
  localparam logic [7:0] SACFG_MASK_SENSOR_CTRL = 8'h0F;
  localparam logic [1:0] SACFG_MON_ON = 2'h3;

  // ****************************************
  // axi responses
  // ****************************************
  localparam logic [1:0] SACFG_RESP_OKAY = 2'h0;
  localparam logic [1:0] SACFG_RESP_SLVERR = 2'h2;

endpackage : sacfg_pkg

// File: design/sacfg_top.sv
// sacfg_top: sensor limit, alarm enable registers and limit comparators
// assumes measurements are synchronous to clk, 3-bit wide, valid when strobed
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

module sacfg_top
  import sacfg_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [SACFG_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [SACFG_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] volt0_reading,
  input wire logic [2:0] volt1_reading,
  input wire logic [2:0] temp_reading,
  input wire logic reading_valid,
  input wire logic [5:0] camera_input_events,
  input wire logic [1:0] return_link_events,
  output logic [5:0] sensor_alarm,
  output logic [5:0] camera_input_alarm,
  output logic [1:0] return_link_alarm
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [2:0] sacfg_upper(input logic [7:0] lim);
    sacfg_upper = lim[SACFG_UPPER_LSB +: SACFG_LIMIT_W];
  endfunction : sacfg_upper

  function automatic logic [2:0] sacfg_lower(input logic [7:0] lim);
    sacfg_lower = lim[SACFG_LOWER_LSB +: SACFG_LIMIT_W];
  endfunction : sacfg_lower

  function automatic logic [7:0] sacfg_merge(input logic [7:0] old, input logic [7:0] wd,
                                             input logic lane0, input logic [7:0] mask);
    sacfg_merge = lane0 ? (wd & mask) : old;
  endfunction : sacfg_merge

  function automatic logic [7:0] sacfg_index(input logic [SACFG_ADDR_W-1:0] a);
    sacfg_index = a[SACFG_ADDR_W-1:2];
  endfunction : sacfg_index

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] volt0_limits;
  logic [7:0] volt1_limits;
  logic [7:0] temp_limits;
  logic [7:0] camera_input_alarm_enables;
  logic [7:0] monitor_alarm_enables;
  logic [7:0] return_link_alarm_enables;
  logic [7:0] sensor_ctrl;
  logic [5:0] sensor_status;
  logic [2:0] volt0_peak_reading;
  logic [2:0] volt0_floor_reading;
  logic [2:0] volt1_peak_reading;
  logic [2:0] volt1_floor_reading;
  logic volt0_seen;
  logic volt1_seen;

  logic [SACFG_ADDR_W-1:0] aw_addr;
  logic aw_held;
  logic [7:0] w_data;
  logic w_lane0;
  logic w_held;
  logic do_write;
  logic [7:0] wr_idx;
  logic wr_hit;
  logic status_clear;

  logic monitors_on;
  logic volt0_sensing;
  logic volt1_sensing;
  logic [5:0] next_status_set;

  assign monitors_on = (sensor_ctrl[SACFG_MON_EN_LSB +: 2] == SACFG_MON_ON);
  assign volt0_sensing = monitors_on & sensor_ctrl[SACFG_VSEL_LSB];
  assign volt1_sensing = monitors_on & sensor_ctrl[SACFG_VSEL_LSB + 1];

  // ****************************************
  // write channel
  // ****************************************
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign wr_idx = sacfg_index(aw_addr);
  assign wr_hit = (wr_idx >= SACFG_IDX_VOLT0_LIMITS && wr_idx <= SACFG_IDX_SPARE) ||
                  wr_idx == SACFG_IDX_SENSOR_CTRL || wr_idx == SACFG_IDX_STATUS;
  assign status_clear = do_write && wr_idx == SACFG_IDX_STATUS && w_lane0;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b0;
    end
    else if (do_write)
    begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b0;
    end
    else if (!aw_held)
    begin
      s_axi_awready <= ~s_axi_awready | ~s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      w_held <= 1'b0;
      w_data <= '0;
      w_lane0 <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else if (do_write)
    begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else if (!w_held)
    begin
      s_axi_wready <= ~s_axi_wready | ~s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SACFG_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? SACFG_RESP_OKAY : SACFG_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      volt0_limits <= SACFG_RST_LIMITS;
      volt1_limits <= SACFG_RST_LIMITS;
      temp_limits <= SACFG_RST_LIMITS;
      camera_input_alarm_enables <= SACFG_RST_CAM_EN;
      monitor_alarm_enables <= SACFG_RST_MON_EN;
      return_link_alarm_enables <= SACFG_RST_RET_EN;
      sensor_ctrl <= SACFG_RST_SENSOR_CTRL;
    end
    else if (do_write)
    begin
      if (wr_idx == SACFG_IDX_VOLT0_LIMITS)
        volt0_limits <= sacfg_merge(volt0_limits, w_data, w_lane0, SACFG_MASK_LIMITS);
      else if (wr_idx == SACFG_IDX_VOLT1_LIMITS)
        volt1_limits <= sacfg_merge(volt1_limits, w_data, w_lane0, SACFG_MASK_LIMITS);
      else if (wr_idx == SACFG_IDX_TEMP_LIMITS)
        temp_limits <= sacfg_merge(temp_limits, w_data, w_lane0, SACFG_MASK_LIMITS);
      else if (wr_idx == SACFG_IDX_CAM_EN)
        camera_input_alarm_enables <= sacfg_merge(camera_input_alarm_enables, w_data,
                                                  w_lane0, SACFG_MASK_CAM_EN);
      else if (wr_idx == SACFG_IDX_MON_EN)
        monitor_alarm_enables <= sacfg_merge(monitor_alarm_enables, w_data,
                                             w_lane0, SACFG_MASK_MON_EN);
      else if (wr_idx == SACFG_IDX_RET_EN)
        return_link_alarm_enables <= sacfg_merge(return_link_alarm_enables, w_data,
                                                 w_lane0, SACFG_MASK_RET_EN);
      else if (wr_idx == SACFG_IDX_SENSOR_CTRL)
        sensor_ctrl <= sacfg_merge(sensor_ctrl, w_data, w_lane0, SACFG_MASK_SENSOR_CTRL);
    end
  end

  // ****************************************
  // limit comparison and status flags
  // ****************************************
  always_comb
  begin
    next_status_set = '0;
    if (reading_valid)
    begin
      next_status_set[SACFG_ST_VOLT0_OVER_ALARM_EN] = volt0_sensing &&
        volt0_reading > sacfg_upper(volt0_limits);
      next_status_set[SACFG_ST_VOLT0_UNDER_ALARM_EN] = volt0_sensing &&
        volt0_reading < sacfg_lower(volt0_limits);
      next_status_set[SACFG_ST_VOLT1_OVER_ALARM_EN] = volt1_sensing &&
        volt1_reading > sacfg_upper(volt1_limits);
      next_status_set[SACFG_ST_VOLT1_UNDER_ALARM_EN] = volt1_sensing &&
        volt1_reading < sacfg_lower(volt1_limits);
      next_status_set[SACFG_ST_T_OVER] = monitors_on &&
        temp_reading > sacfg_upper(temp_limits);
      next_status_set[SACFG_ST_T_UNDER] = monitors_on &&
        temp_reading < sacfg_lower(temp_limits);
    end
  end

  // sticky; a new set wins over a write-one clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sensor_status <= '0;
    else if (status_clear)
      sensor_status <= (sensor_status & ~w_data[5:0]) | next_status_set;
    else
      sensor_status <= sensor_status | next_status_set;
  end

  // ****************************************
  // peak and floor readings
  // ****************************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      volt0_seen <= 1'b0;
      volt0_peak_reading <= '0;
      volt0_floor_reading <= '0;
    end
    else if (reading_valid && volt0_sensing)
    begin
      volt0_seen <= 1'b1;
      if (!volt0_seen || volt0_reading > volt0_peak_reading)
        volt0_peak_reading <= volt0_reading;
      if (!volt0_seen || volt0_reading < volt0_floor_reading)
        volt0_floor_reading <= volt0_reading;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      volt1_seen <= 1'b0;
      volt1_peak_reading <= '0;
      volt1_floor_reading <= '0;
    end
    else if (reading_valid && volt1_sensing)
    begin
      volt1_seen <= 1'b1;
      if (!volt1_seen || volt1_reading > volt1_peak_reading)
        volt1_peak_reading <= volt1_reading;
      if (!volt1_seen || volt1_reading < volt1_floor_reading)
        volt1_floor_reading <= volt1_reading;
    end
  end

  // ****************************************
  // gated alarm outputs
  // ****************************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sensor_alarm <= '0;
      camera_input_alarm <= '0;
      return_link_alarm <= '0;
    end
    else
    begin
      sensor_alarm <= sensor_status & monitor_alarm_enables[5:0];
      camera_input_alarm <= camera_input_events & camera_input_alarm_enables[5:0];
      return_link_alarm <= return_link_events & return_link_alarm_enables[1:0];
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  logic [7:0] rd_idx;
  logic [7:0] rd_byte;
  logic rd_hit;

  assign rd_idx = sacfg_index(s_axi_araddr);

  always_comb
  begin
    rd_byte = '0;
    rd_hit = 1'b1;
    if (rd_idx == SACFG_IDX_VOLT0_LIMITS)
      rd_byte = volt0_limits;
    else if (rd_idx == SACFG_IDX_VOLT1_LIMITS)
      rd_byte = volt1_limits;
    else if (rd_idx == SACFG_IDX_TEMP_LIMITS)
      rd_byte = temp_limits;
    else if (rd_idx == SACFG_IDX_CAM_EN)
      rd_byte = camera_input_alarm_enables;
    else if (rd_idx == SACFG_IDX_MON_EN)
      rd_byte = monitor_alarm_enables;
    else if (rd_idx == SACFG_IDX_RET_EN)
      rd_byte = return_link_alarm_enables;
    else if (rd_idx == SACFG_IDX_SPARE)
      rd_byte = SACFG_RST_SPARE;
    else if (rd_idx == SACFG_IDX_SENSOR_CTRL)
      rd_byte = sensor_ctrl;
    else if (rd_idx == SACFG_IDX_STATUS)
      rd_byte = {2'h0, sensor_status};
    else if (rd_idx == SACFG_IDX_VOLT0_PEAK)
      rd_byte = {5'h00, volt0_peak_reading};
    else if (rd_idx == SACFG_IDX_VOLT0_FLOOR)
      rd_byte = {5'h00, volt0_floor_reading};
    else if (rd_idx == SACFG_IDX_VOLT1_PEAK)
      rd_byte = {5'h00, volt1_peak_reading};
    else if (rd_idx == SACFG_IDX_VOLT1_FLOOR)
      rd_byte = {5'h00, volt1_floor_reading};
    else if (rd_idx == SACFG_IDX_ALARM)
      rd_byte = {2'h0, sensor_alarm};
    else
      rd_hit = 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= SACFG_RESP_OKAY;
    end
    else if (s_axi_rvalid)
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_hit ? SACFG_RESP_OKAY : SACFG_RESP_SLVERR;
    end
    else
    begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : sacfg_top

// File: verification/sacfg_assertions.sv
// sacfg_assertions: port checks of the sensor alarm config block
// assumes sacfg_top ports, clock clk, async active-low reset_n
`timescale 1ns/1ps
module sacfg_checker
  import sacfg_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] camera_input_events,
  input wire logic [1:0] return_link_events,
  input wire logic [5:0] sensor_alarm,
  input wire logic [5:0] camera_input_alarm,
  input wire logic [1:0] return_link_alarm
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ****************************************
  // assertions
  // ****************************************
  cam_alarm_gate_a: assert property ((camera_input_alarm & ~$past(camera_input_events)) == 6'h00)
    else $error("camera alarm without its event");
  ret_alarm_gate_a: assert property ((return_link_alarm & ~$past(return_link_events)) == 2'h0)
    else $error("return link alarm without its event");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:8] == 24'h000000)
    else $error("read channel misbehaves");
  slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == SACFG_RESP_SLVERR
    |-> s_axi_rdata == 32'h00000000) else $error("error read returns data");
  cover property (s_axi_bvalid && s_axi_bresp == SACFG_RESP_SLVERR);
  cover property (sensor_alarm != 6'h00);
  cover property (camera_input_alarm != 6'h00);
  cover property (s_axi_rvalid && !s_axi_rready);
endmodule : sacfg_checker

bind sacfg_top sacfg_checker u_chk (.clk(clk), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .camera_input_events(camera_input_events), .return_link_events(return_link_events),
  .sensor_alarm(sensor_alarm), .camera_input_alarm(camera_input_alarm),
  .return_link_alarm(return_link_alarm));

// File: verification/testbench.sv
// testbench: register, gating and limit scenarios for sacfg_top
// assumes 125 MHz clk, axi4-lite byte address = 4 * register index
`timescale 1ns/1ps
module testbench
  import sacfg_pkg::*;
;
  logic clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rv;
  logic [SACFG_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, ret_ev, ret_al, rs;
  logic [2:0] v0, v1, tr;
  logic [5:0] cam_ev, cam_al, sen_al;
  logic [7:0] rd;
  int n_fail, total_checks, slow;
  logic [7:0] idxs [8] = '{8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h40};
  logic [7:0] rstv [8] = '{8'h62, 8'h62, 8'h62, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h0C};
  logic [7:0] msks [8] = '{8'h77, 8'h77, 8'h77, 8'h3F, 8'h3F, 8'h03, 8'h00, 8'h0F};
  logic [7:0] ctls [4] = '{8'h0C, 8'h0E, 8'h0D, 8'h03};
  logic [11:0] rdgs [4] = '{12'h117, 12'h714, 12'h114, 12'h777};
  logic [7:0] stex [4] = '{8'h20, 8'h04, 8'h01, 8'h00};

  sacfg_top u_dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .volt0_reading(v0), .volt1_reading(v1), .temp_reading(tr), .reading_valid(rv),
    .camera_input_events(cam_ev), .return_link_events(ret_ev), .sensor_alarm(sen_al),
    .camera_input_alarm(cam_al), .return_link_alarm(ret_al));

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic timeout;
    n_fail++;
    $display("CHECK FAILED t=%0t bus wait ran out", $time);
    print_verdict();
  endtask : timeout

  // ****************************************
  // bus and sample tasks
  // ****************************************
  task automatic axi_write(input logic [7:0] idx, input logic [7:0] val, input logic [1:0] exp);
    int n;
    logic aw_done, w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (slow == 0);
    while (!(aw_done && w_done))
    begin
      @(posedge clk);
      if (!aw_done && awready === 1'b1)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
      n++;
      if (n > 50) timeout();
    end
    while (bvalid !== 1'b1)
    begin
      @(posedge clk);
      n++;
      if (n > 100) timeout();
    end
    if (slow > 0)
    begin
      repeat (slow) @(posedge clk);
      bready <= 1'b1;
      @(posedge clk);
    end
    check(bresp, exp, "write response");
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] idx, output logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= (slow == 0);
    do
    begin
      @(posedge clk);
      n++;
      if (n > 50) timeout();
    end
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1)
    begin
      @(posedge clk);
      n++;
      if (n > 100) timeout();
    end
    if (slow > 0)
    begin
      repeat (slow) @(posedge clk);
      rready <= 1'b1;
      @(posedge clk);
    end
    d = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task automatic expect_reg(input logic [7:0] idx, input logic [7:0] val, input logic [1:0] resp);
    axi_read(idx, rd, rs);
    check(rd, val, "register value");
    check(rs, resp, "read response");
  endtask : expect_reg

  task automatic sample(input logic [2:0] a, input logic [2:0] b, input logic [2:0] c);
    @(posedge clk);
    v0 <= a;
    v1 <= b;
    tr <= c;
    rv <= 1'b1;
    @(posedge clk);
    rv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : sample

  // ****************************************
  // stimulus
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready, rv} = '0;
    {awaddr, araddr, wdata, v0, v1, tr, cam_ev, ret_ev} = '0;
    wstrb = 4'hF;
    n_fail = 0;
    total_checks = 0;
    slow = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++)
      expect_reg(idxs[i], rstv[i], SACFG_RESP_OKAY);
    for (int i = 0; i < 8; i++)
    begin
      axi_write(idxs[i], 8'hFF, SACFG_RESP_OKAY);
      expect_reg(idxs[i], msks[i], SACFG_RESP_OKAY);
    end
    slow = 3;
    axi_write(8'h30, 8'h55, SACFG_RESP_SLVERR);
    axi_write(8'h42, 8'h55, SACFG_RESP_SLVERR);
    expect_reg(8'h30, 8'h00, SACFG_RESP_SLVERR);
    slow = 0;
    for (int i = 0; i < 2; i++)
    begin
      axi_write(8'h1C, {2'b00, 6'h15 << i}, SACFG_RESP_OKAY);
      axi_write(8'h1E, {6'h00, 2'b01 << i}, SACFG_RESP_OKAY);
      @(posedge clk);
      cam_ev <= 6'h3F;
      ret_ev <= 2'b11;
      repeat (2) @(posedge clk);
      check(cam_al, 6'h15 << i, "camera alarm");
      check(ret_al, 2'b01 << i, "return alarm");
      cam_ev <= 6'h00;
      ret_ev <= 2'b00;
    end
    axi_write(8'h19, 8'h52, SACFG_RESP_OKAY);
    axi_write(8'h1A, 8'h62, SACFG_RESP_OKAY);
    axi_write(8'h1B, 8'h62, SACFG_RESP_OKAY);
    sample(3'h6, 3'h6, 3'h7);
    expect_reg(8'h41, 8'h22, SACFG_RESP_OKAY);
    check(sen_al, 8'h22, "sensor alarm");
    axi_write(8'h41, 8'hFF, SACFG_RESP_OKAY);
    axi_write(8'h1D, 8'h00, SACFG_RESP_OKAY);
    sample(3'h1, 3'h7, 3'h0);
    expect_reg(8'h41, 8'h19, SACFG_RESP_OKAY);
    check(sen_al, 8'h00, "sensor alarm masked");
    axi_write(8'h1D, 8'h3F, SACFG_RESP_OKAY);
    expect_reg(8'h46, 8'h19, SACFG_RESP_OKAY);
    check(sen_al, 8'h19, "sensor alarm unmasked");
    expect_reg(8'h19, 8'h52, SACFG_RESP_OKAY);
    expect_reg(8'h42, 8'h06, SACFG_RESP_OKAY);
    expect_reg(8'h43, 8'h01, SACFG_RESP_OKAY);
    expect_reg(8'h44, 8'h07, SACFG_RESP_OKAY);
    expect_reg(8'h45, 8'h06, SACFG_RESP_OKAY);
    for (int i = 0; i < 4; i++)
    begin
      axi_write(8'h40, ctls[i], SACFG_RESP_OKAY);
      axi_write(8'h41, 8'hFF, SACFG_RESP_OKAY);
      sample(rdgs[i][10:8], rdgs[i][6:4], rdgs[i][2:0]);
      expect_reg(8'h41, stex[i], SACFG_RESP_OKAY);
    end
    print_verdict();
  end
endmodule : testbench
